// >>> verilog/pio1_port.v
/*
 * eight-pin general-purpose port with direction, output latch and pin-level
 * view registers behind an AXI4-Lite slave. assumes power-state inputs are
 * synchronous to mclk; pins pass a two-flop synchroniser; timer and address sources are external.
 */
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/100ps
`include "pio1_map.vh"

// Summary of operation
// - direction register eight bits, write only
// - direction one means output, zero input
// - direction cleared by power-on and hardware standby
// - manual reset clears timer override, keeps registers
// - standby control picks hold or release address pins
// - modes 1-3, 7: all pins plain I/O
// - modes 4-6: pins 3-0 drive address when output
// - modes 4-6: pins 7-4 plain I/O
// - output latch eight bits read/write drives pins
// - output latch cleared by power-on and hardware standby
// - pin view read only, writes ignored
// - view returns latch if output, pin if input
// - view frozen in manual reset and software standby
// - each pin selects I/O or timer; pins 3-0 also address
// - enabled timer output overrides general output
module pio1_port (
    // clock and reset
    input  wire                     mclk,
    input  wire                     rst,
    // power state and operating mode
    input  wire [`PIO1_PWR_W-1:0]   pwr_state,
    input  wire [`PIO1_MODE_W-1:0]  op_mode,
    // shared sources
    input  wire [`PIO1_PIN_W-1:0]   addr_upper,
    input  wire [`PIO1_PIN_W-1:0]   tmr_out_val,
    // pins
    input  wire [`PIO1_PIN_W-1:0]   pin_in,
    output reg  [`PIO1_PIN_W-1:0]   pin_out,
    output reg  [`PIO1_PIN_W-1:0]   pin_oe_n,
    output reg  [`PIO1_PIN_W-1:0]   tmr_in_level,
    // axi4-lite write address
    input  wire [`PIO1_ADDR_W-1:0]  s_axi_awaddr,
    input  wire                     s_axi_awvalid,
    output reg                      s_axi_awready,
    // axi4-lite write data
    input  wire [31:0]              s_axi_wdata,
    input  wire [3:0]               s_axi_wstrb,
    input  wire                     s_axi_wvalid,
    output reg                      s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]               s_axi_bresp,
    output reg                      s_axi_bvalid,
    input  wire                     s_axi_bready,
    // axi4-lite read address
    input  wire [`PIO1_ADDR_W-1:0]  s_axi_araddr,
    input  wire                     s_axi_arvalid,
    output reg                      s_axi_arready,
    // axi4-lite read data
    output reg  [31:0]              s_axi_rdata,
    output reg  [1:0]               s_axi_rresp,
    output reg                      s_axi_rvalid,
    input  wire                     s_axi_rready
);

    // ==========================================================
    // decode helpers
    function is_mapped;
        input [`PIO1_ADDR_W-1:0] a;
        begin
            is_mapped = (a == `PIO1_OFF_DIRECTION) || (a == `PIO1_OFF_LEVEL_VIEW) ||
                        (a == `PIO1_OFF_OUT_LATCH) || (a == `PIO1_OFF_STBY_CTRL) ||
                        (a == `PIO1_OFF_TMR_CTRL)  || (a == `PIO1_OFF_STATUS);
        end
    endfunction

    function addr_mode_of;
        input [`PIO1_MODE_W-1:0] m;
        begin
            addr_mode_of = (m >= `PIO1_MODE_ADDR_LO) && (m <= `PIO1_MODE_ADDR_HI);
        end
    endfunction

    // ==========================================================
    // state
    reg  [`PIO1_PIN_W-1:0] dir_reg;
    reg  [`PIO1_PIN_W-1:0] latch_reg;
    reg  [`PIO1_PIN_W-1:0] tmr_en_reg;
    reg                    stby_hold_reg;
    reg  [`PIO1_PIN_W-1:0] view_reg;
    reg  [`PIO1_PIN_W-1:0] sync1_reg;
    reg  [`PIO1_PIN_W-1:0] sync2_reg;
    reg  [`PIO1_ADDR_W-1:0] aw_reg;
    reg  [31:0]            wd_reg;
    reg  [3:0]             ws_reg;
    reg                    aw_have;
    reg                    w_have;

    wire hw_stby   = (pwr_state == `PIO1_PWR_HW_STBY);
    wire manual    = (pwr_state == `PIO1_PWR_MANUAL);
    wire sw_stby   = (pwr_state == `PIO1_PWR_SW_STBY);
    wire clear_all = rst | hw_stby;
    wire frozen    = manual | sw_stby;
    wire addr_mode = addr_mode_of(op_mode);

    // ==========================================================
    // pin synchroniser; first stage feeds only the second
    always @(posedge mclk) begin
        sync1_reg <= pin_in;
        sync2_reg <= sync1_reg;
    end

    // ==========================================================
    // write channel: address and data accepted in either order
    wire do_write = aw_have && w_have && !s_axi_bvalid;
    wire w_lane0  = ws_reg[0];

    always @(posedge mclk) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `PIO1_RESP_OKAY;
            aw_have       <= 1'b0;
            w_have        <= 1'b0;
            aw_reg        <= {`PIO1_ADDR_W{1'b0}};
            wd_reg        <= 32'h0000_0000;
            ws_reg        <= 4'h0;
        end else begin
            s_axi_awready <= !aw_have && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_have && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have <= 1'b1;
                aw_reg  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have <= 1'b1;
                wd_reg <= s_axi_wdata;
                ws_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_have      <= 1'b0;
                w_have       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= is_mapped(aw_reg) ? `PIO1_RESP_OKAY : `PIO1_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // control registers; kept through manual reset and software standby
    always @(posedge mclk) begin
        if (clear_all) begin
            dir_reg   <= `PIO1_DIR_RST;
            latch_reg <= `PIO1_OUT_RST;
        end else if (do_write && w_lane0) begin
            if (aw_reg == `PIO1_OFF_DIRECTION)
                dir_reg <= wd_reg[`PIO1_PIN_W-1:0];
            if (aw_reg == `PIO1_OFF_OUT_LATCH)
                latch_reg <= wd_reg[`PIO1_PIN_W-1:0];
            // writes to the level view fall through unused
        end
    end

    always @(posedge mclk) begin
        if (clear_all) begin
            stby_hold_reg <= 1'b0;
        end else if (do_write && w_lane0 && aw_reg == `PIO1_OFF_STBY_CTRL) begin
            stby_hold_reg <= wd_reg[`PIO1_STBY_HOLD_BIT];
        end
    end

    // timer unit is reinitialised by a manual reset, dropping overrides
    always @(posedge mclk) begin
        if (clear_all || manual) begin
            tmr_en_reg <= `PIO1_TMR_RST;
        end else if (do_write && w_lane0 && aw_reg == `PIO1_OFF_TMR_CTRL) begin
            tmr_en_reg <= wd_reg[`PIO1_PIN_W-1:0];
        end
    end

    // ==========================================================
    // pin-level view: latch bit for outputs, synced pin for inputs
    always @(posedge mclk) begin
        if (clear_all) begin
            view_reg <= sync2_reg;
        end else if (!frozen) begin
            view_reg <= (dir_reg & latch_reg) | (~dir_reg & sync2_reg);
        end
    end

    // ==========================================================
    // pin drive
    wire [`PIO1_PIN_W-1:0] mux_val;
    wire [`PIO1_PIN_W-1:0] mux_on;

    pio1_pin_mux u_mux (
        .dir_bits   (dir_reg),
        .latch_bits (latch_reg),
        .addr_mode  (addr_mode),
        .addr_bits  (addr_upper),
        .tmr_en     (tmr_en_reg),
        .tmr_val    (tmr_out_val),
        .drive_val  (mux_val),
        .drive_on   (mux_on)
    );

    // address pins float in software standby unless hold is set
    wire [`PIO1_PIN_W-1:0] addr_mask = addr_mode ? {{`PIO1_PIN_W-4{1'b0}}, 4'hf}
                                                 : {`PIO1_PIN_W{1'b0}};
    wire [`PIO1_PIN_W-1:0] float_mask = (sw_stby && !stby_hold_reg) ? addr_mask
                                                                  : {`PIO1_PIN_W{1'b0}};

    always @(posedge mclk) begin
        if (clear_all) begin
            pin_out      <= `PIO1_OUT_RST;
            pin_oe_n     <= ~`PIO1_DIR_RST;
            tmr_in_level <= {`PIO1_PIN_W{1'b0}};
        end else begin
            pin_out      <= mux_val;
            pin_oe_n     <= ~(mux_on & ~float_mask);
            tmr_in_level <= sync2_reg;
        end
    end

    // ==========================================================
    // read channel, one cycle from address to data
    reg [31:0] rd_word;
    always @* begin
        rd_word = 32'h0000_0000;
        case (s_axi_araddr)
            `PIO1_OFF_DIRECTION:  rd_word[`PIO1_PIN_W-1:0] = `PIO1_UNDEF_READ;
            `PIO1_OFF_LEVEL_VIEW: rd_word[`PIO1_PIN_W-1:0] = view_reg;
            `PIO1_OFF_OUT_LATCH:  rd_word[`PIO1_PIN_W-1:0] = latch_reg;
            `PIO1_OFF_STBY_CTRL:  rd_word[`PIO1_STBY_HOLD_BIT] = stby_hold_reg;
            `PIO1_OFF_TMR_CTRL:   rd_word[`PIO1_PIN_W-1:0] = tmr_en_reg;
            `PIO1_OFF_STATUS:     rd_word[`PIO1_PIN_W-1:0] = mux_on;
            default:              rd_word = 32'h0000_0000;
        endcase
    end

    always @(posedge mclk) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `PIO1_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= is_mapped(s_axi_araddr) ? `PIO1_RESP_OKAY
                                                        : `PIO1_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

// >>> verilog/pio1_map.vh
/*
 * register map, field positions, reset values and mode codes for the
 * eight-pin general-purpose port. assumes a 32-bit AXI4-Lite register bus.
 */
`ifndef PIO1_MAP_VH
`define PIO1_MAP_VH

// ==========================================================
// register byte addresses (low 16 bits of the system address)
`define PIO1_ADDR_W          16
`define PIO1_OFF_DIRECTION   16'hfeb0
`define PIO1_OFF_LEVEL_VIEW  16'hff50
`define PIO1_OFF_OUT_LATCH   16'hff60
`define PIO1_OFF_STBY_CTRL   16'hff70
`define PIO1_OFF_TMR_CTRL    16'hff74
`define PIO1_OFF_STATUS      16'hff78

// ==========================================================
// widths and reset values
`define PIO1_PIN_W           8
`define PIO1_DIR_RST         8'h00
`define PIO1_OUT_RST         8'h00
`define PIO1_TMR_RST         8'h00
`define PIO1_UNDEF_READ      8'h00

// ==========================================================
// field positions
`define PIO1_ADDR_PINS_HI    3
`define PIO1_MODE_W          3
`define PIO1_STBY_HOLD_BIT   0

// ==========================================================
// operating mode codes and power states
`define PIO1_MODE_ADDR_LO    3'h4
`define PIO1_MODE_ADDR_HI    3'h6
`define PIO1_PWR_W           2
`define PIO1_PWR_RUN         2'h0
`define PIO1_PWR_MANUAL      2'h1
`define PIO1_PWR_SW_STBY     2'h2
`define PIO1_PWR_HW_STBY     2'h3

// ==========================================================
// bus responses
`define PIO1_RESP_OKAY       2'h0
`define PIO1_RESP_SLVERR     2'h2

`endif

// >>> verilog/pio1_pin_mux.v
/*
 * per-pin output mux for the port: chooses timer, address or latch data
 * and the output enable. assumes all inputs already registered/synchronous.
 */
`timescale 1ns/100ps
`include "pio1_map.vh"

module pio1_pin_mux (
    // control
    input  wire [`PIO1_PIN_W-1:0] dir_bits,
    input  wire [`PIO1_PIN_W-1:0] latch_bits,
    input  wire                   addr_mode,
    input  wire [`PIO1_PIN_W-1:0] addr_bits,
    // timer override
    input  wire [`PIO1_PIN_W-1:0] tmr_en,
    input  wire [`PIO1_PIN_W-1:0] tmr_val,
    // result
    output wire [`PIO1_PIN_W-1:0] drive_val,
    output wire [`PIO1_PIN_W-1:0] drive_on
);

    genvar i;
    generate
        for (i = 0; i < `PIO1_PIN_W; i = i + 1) begin : g_pin
            wire is_addr;
            assign is_addr = addr_mode && (i <= `PIO1_ADDR_PINS_HI);
            // timer output wins over everything else
            assign drive_on[i]  = tmr_en[i] | dir_bits[i];
            assign drive_val[i] = tmr_en[i] ? tmr_val[i] :
                                  is_addr   ? addr_bits[i] : latch_bits[i];
        end
    endgenerate

endmodule

// >>> sim/pio1_port_asserts.sv
/*
 * checker for the port: bus handshakes, pin reset states, synchroniser.
 * assumes it is bound to pio1_port and sees only that module's ports.
 */
`timescale 1ns/100ps
`include "pio1_map.vh"
module pio1_port_asserts (
    input logic        mclk, rst, s_axi_awready, s_axi_wready, s_axi_bvalid,
    input logic        s_axi_bready, s_axi_arready, s_axi_rvalid, s_axi_rready,
    input logic [1:0]  pwr_state, s_axi_bresp,
    input logic [7:0]  pin_in, pin_out, pin_oe_n, tmr_in_level,
    input logic [31:0] s_axi_rdata
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // ==========================================================
    // pins
    a_reset_pins_idle: assert property (disable iff (1'b0)
        rst [*2] |-> pin_oe_n == 8'hff && pin_out == 8'h00) else $error("pins driven in reset");
    a_hwstby_release: assert property (
        pwr_state == `PIO1_PWR_HW_STBY [*2] |-> pin_oe_n == 8'hff) else $error("pins driven");
    // two flops at least: a fresh level must not show one cycle later
    a_sync_settles: assert property (
        (pwr_state == 2'h0 && $stable(pin_in)) [*5] |-> tmr_in_level == pin_in)
        else $error("synced level wrong");
    a_sync_delayed: assert property (
        (pwr_state == 2'h0 && $stable(pin_in)) [*5] ##1 !$stable(pin_in) ##1 $stable(pin_in)
        |-> tmr_in_level != pin_in) else $error("pin level not delayed");
    // ==========================================================
    // bus
    a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped");
    a_bresp_legal: assert property (s_axi_bvalid |->
        s_axi_bresp inside {`PIO1_RESP_OKAY, `PIO1_RESP_SLVERR}) else $error("bad bresp");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
    a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar taken");
    a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready long");
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_hwstby: cover property (pwr_state == `PIO1_PWR_HW_STBY);
endmodule
bind pio1_port pio1_port_asserts u_chk (.*);

// >>> sim/pio1_pin_model.sv
/*
 * outside circuitry on the eight pins: a driver on every released pin.
 * assumes active-low output enables from the port.
 */
`timescale 1ns/100ps
module pio1_pin_model (
    input  logic [7:0] pin_out, pin_oe_n, ext_val,
    output logic [7:0] pin_level
);
    // driven pins read back their own value, released ones the outside
    assign pin_level = (pin_out & ~pin_oe_n) | (ext_val & pin_oe_n);
endmodule

// >>> sim/tb.sv
/*
 * self-checking bench for the port: axi4-lite master, modes, power states.
 * assumes the checker binds itself and the pin model closes the pins.
 */
`timescale 1ns/100ps
`include "pio1_map.vh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module tb;
    logic        mclk = 1'b0, rst = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  pwr_state = 2'h0, s_axi_bresp, s_axi_rresp;
    logic [2:0]  op_mode = 3'h1;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [7:0]  addr_upper = 8'h03, tmr_out_val = 8'h00, ext_val = 8'h3c;
    logic [7:0]  pin_in, pin_out, pin_oe_n, tmr_in_level;
    logic [15:0] s_axi_awaddr = 16'h0000, s_axi_araddr = 16'h0000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    int          fail_count = 0, n_checks = 0, cyc = 0;
    pio1_port u_pio1_port (.*);
    pio1_pin_model u_pio1_pin_model (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
                                     .ext_val(ext_val), .pin_level(pin_in));
    initial forever #4 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            print_verdict();
        end
    end
    // ==========================================================
    // bus master
    task automatic tk(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_awvalid || s_axi_wvalid);
        // slow response acceptance on purpose
        @(posedge mclk);
        s_axi_bready <= 1'b1;
        do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        `CHK(s_axi_bresp, er)
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic [1:0] er);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge mclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        @(posedge mclk);
        s_axi_rready <= 1'b1;
        do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        `CHK(s_axi_rresp, er)
        if (er == `PIO1_RESP_OKAY) `CHK(s_axi_rdata, {24'h000000, e})
    endtask
    // ==========================================================
    // scenarios
    task automatic t_reset();
        `CHK(pin_oe_n, 8'hff)
        `CHK(pin_out, 8'h00)
        rd(`PIO1_OFF_OUT_LATCH, 8'h00, `PIO1_RESP_OKAY);
        rd(`PIO1_OFF_DIRECTION, `PIO1_UNDEF_READ, `PIO1_RESP_OKAY);
        rd(`PIO1_OFF_LEVEL_VIEW, 8'h3c, `PIO1_RESP_OKAY);
        rd(16'h0010, 8'h00, `PIO1_RESP_SLVERR);
        wr(16'h0010, 8'h00, `PIO1_RESP_SLVERR);
        $display("t_reset done");
    endtask
    task automatic t_modes();
        wr(`PIO1_OFF_OUT_LATCH, 8'ha5, `PIO1_RESP_OKAY);
        // the latch already drives the pin value by the time bvalid is taken
        `CHK(pin_out, 8'ha5)
        wr(`PIO1_OFF_DIRECTION, 8'hff, `PIO1_RESP_OKAY);
        for (int m = 1; m < 8; m++) begin
            op_mode <= m[2:0];
            tk(3);
            `CHK(pin_oe_n, 8'h00)
            `CHK(pin_out, (m >= 4 && m <= 6) ? 8'ha3 : 8'ha5)
        end
        op_mode <= 3'h5;
        wr(`PIO1_OFF_DIRECTION, 8'hf0, `PIO1_RESP_OKAY);
        tk(6);
        `CHK(pin_oe_n, 8'h0f)
        `CHK(pin_out[7:4], 4'ha)
        rd(`PIO1_OFF_LEVEL_VIEW, 8'hac, `PIO1_RESP_OKAY);
        wr(`PIO1_OFF_LEVEL_VIEW, 8'h00, `PIO1_RESP_OKAY);
        rd(`PIO1_OFF_LEVEL_VIEW, 8'hac, `PIO1_RESP_OKAY);
        rd(`PIO1_OFF_OUT_LATCH, 8'ha5, `PIO1_RESP_OKAY);
        $display("t_modes done");
    endtask
    task automatic t_timer();
        op_mode <= 3'h1;
        // pin 0 left as input so that the override must force its enable
        wr(`PIO1_OFF_DIRECTION, 8'hfe, `PIO1_RESP_OKAY);
        wr(`PIO1_OFF_TMR_CTRL, 8'h01, `PIO1_RESP_OKAY);
        tk(3);
        `CHK(pin_out, 8'ha4)
        `CHK(pin_oe_n, 8'h00)
        rd(`PIO1_OFF_TMR_CTRL, 8'h01, `PIO1_RESP_OKAY);
        rd(`PIO1_OFF_STATUS, 8'hff, `PIO1_RESP_OKAY);
        pwr_state <= `PIO1_PWR_MANUAL;
        tk(3);
        `CHK(pin_out, 8'ha5)
        `CHK(pin_oe_n, 8'h01)
        pwr_state <= `PIO1_PWR_RUN;
        tk(3);
        `CHK(pin_out, 8'ha5)
        rd(`PIO1_OFF_TMR_CTRL, 8'h00, `PIO1_RESP_OKAY);
        rd(`PIO1_OFF_STATUS, 8'hfe, `PIO1_RESP_OKAY);
        $display("t_timer done");
    endtask
    task automatic t_stby();
        op_mode <= 3'h5;
        wr(`PIO1_OFF_DIRECTION, 8'h0f, `PIO1_RESP_OKAY);
        wr(`PIO1_OFF_STBY_CTRL, 8'h01, `PIO1_RESP_OKAY);
        rd(`PIO1_OFF_STBY_CTRL, 8'h01, `PIO1_RESP_OKAY);
        tk(6);
        pwr_state <= `PIO1_PWR_SW_STBY;
        ext_val   <= 8'hc3;
        tk(6);
        `CHK(pin_oe_n[3:0], 4'h0)
        rd(`PIO1_OFF_LEVEL_VIEW, 8'h35, `PIO1_RESP_OKAY);
        pwr_state <= `PIO1_PWR_RUN;
        wr(`PIO1_OFF_STBY_CTRL, 8'h00, `PIO1_RESP_OKAY);
        pwr_state <= `PIO1_PWR_SW_STBY;
        tk(3);
        `CHK(pin_oe_n[3:0], 4'hf)
        pwr_state <= `PIO1_PWR_RUN;
        rd(`PIO1_OFF_OUT_LATCH, 8'ha5, `PIO1_RESP_OKAY);
        $display("t_stby done");
    endtask
    task automatic t_hw();
        pwr_state <= `PIO1_PWR_HW_STBY;
        tk(3);
        `CHK(pin_oe_n, 8'hff)
        pwr_state <= `PIO1_PWR_RUN;
        tk(6);
        rd(`PIO1_OFF_OUT_LATCH, 8'h00, `PIO1_RESP_OKAY);
        rd(`PIO1_OFF_LEVEL_VIEW, 8'hc3, `PIO1_RESP_OKAY);
        `CHK(pin_oe_n, 8'hff)
        $display("t_hw done");
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        tk(10);
        rst <= 1'b0;
        tk(1);
        t_reset();
        t_modes();
        t_timer();
        t_stby();
        t_hw();
        print_verdict();
    end
endmodule
